/* common/mbb_regs.svh */
// constants for the backplane bus master: widths, strobe map, timing
// assumes one 10 MHz clock; bus lines are idle high through pull-ups
`ifndef MBB_REGS_SVH
`define MBB_REGS_SVH

`define MBB_ADDR_W        16
`define MBB_DATA_W        8
`define MBB_IO_ADDR_W     8
`define MBB_IRQ_W         8
`define MBB_NSTRB         5

// strobe bit positions in the request strobe vector
`define MBB_STRB_MEM_READ 0
`define MBB_STRB_MEM_WRITE 1
`define MBB_STRB_IO_READ  2
`define MBB_STRB_IO_WRITE 3
`define MBB_STRB_INT_ACK  4

// synchroniser field positions
`define MBB_SY_WAIT       0
`define MBB_SY_HOLD       1
`define MBB_SY_AREL       2
`define MBB_SY_DREL       3
`define MBB_SY_DATA       4
`define MBB_SY_IRQ        12
`define MBB_SY_STRB       20
`define MBB_SY_W          25
`define MBB_SY_IDLE       25'h1FFFFFF

// reset values
`define MBB_OC_LVL        1'b0
`define MBB_ADDR_RST      16'h0000
`define MBB_DATA_RST      8'h00
`define MBB_STRB_OE_RST   5'h00
`define MBB_IO_ADDR_HI    8'h00

// timing: one bus phase lasts at least this long
`define MBB_CLK_NS        100
`define MBB_PHASE_NS      200
`define MBB_PHASE_CYC     ((`MBB_PHASE_NS + `MBB_CLK_NS - 1) / `MBB_CLK_NS)
`define MBB_DIV_W         4

`endif

/* common/mbb_pkg.sv */
// types shared by the backplane bus master and its helpers
// assumes mbb_regs.svh for all numeric constants
package mbb_pkg;

  // machine cycle kinds, one per request strobe
  typedef enum logic [2:0] {
    MBB_CYC_MEM_READ,
    MBB_CYC_MEM_WRITE,
    MBB_CYC_IO_READ,
    MBB_CYC_IO_WRITE,
    MBB_CYC_INT_ACK
  } mbb_cyc_e;

  typedef enum logic [2:0] {
    MBB_ST_IDLE,
    MBB_ST_ADDR,
    MBB_ST_STRB,
    MBB_ST_TAIL,
    MBB_ST_HOLD
  } mbb_state_e;

endpackage : mbb_pkg

/* common/mbb_tick_if.sv */
// phase tick carried from the divider to the bus sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface mbb_tick_if;
  logic tick;
  logic run;
  modport gen (output tick, input run);
  modport seq (input tick, output run);
endinterface : mbb_tick_if

`default_nettype wire

/* src/mbb_sync.sv */
// two-flop synchroniser for a vector of bus pins
// assumes the pins are asynchronous to clk_in; reset value is the idle level
`timescale 1ns/1ps
`default_nettype none

module mbb_sync #(
  parameter int            W       = 1,
  parameter logic [W-1:0]  RST_VAL = '1
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] pins_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mbb_sync_s;

  mbb_sync_s r;
  mbb_sync_s r_nxt;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = pins_in;
    r_nxt.s2 = r.s1;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= {RST_VAL, RST_VAL};
    end else begin
      r <= r_nxt;
    end
  end

  assign sync_out = r.s2;

endmodule : mbb_sync

`default_nettype wire

/* src/mbb_phase_div.sv */
// divider that paces the bus phases with a one-cycle tick
// assumes the sequencer holds run high while it needs phase ticks
`timescale 1ns/1ps
`default_nettype none
`include "mbb_regs.svh"

module mbb_phase_div (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  mbb_tick_if.gen   tk
);

  typedef struct packed {
    logic [`MBB_DIV_W-1:0] cnt;
    logic                  tick;
  } mbb_div_s;

  localparam logic [`MBB_DIV_W-1:0] LAST = `MBB_DIV_W'(`MBB_PHASE_CYC - 1);

  mbb_div_s r;
  mbb_div_s r_nxt;

  always_comb begin
    r_nxt      = r;
    r_nxt.tick = 1'b0;
    if (!tk.run) begin
      // restart so the first phase after a request is a full one
      r_nxt.cnt = '0;
    end else if (r.cnt == LAST) begin
      r_nxt.cnt  = '0;
      r_nxt.tick = 1'b1;
    end else begin
      r_nxt.cnt = r.cnt + `MBB_DIV_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign tk.tick = r.tick;

endmodule : mbb_phase_div

`default_nettype wire

/* src/mbb_master.sv */
// processor-side bus master: runs machine cycles on the backplane,
// answers hold requests and obeys the buffer release and wait lines
// assumes pull-ups on every open-collector line and pins outside clk_in
`timescale 1ns/1ps
`default_nettype none
`include "mbb_regs.svh"

// Functional notes
// RL1: master drives 16-bit tri-state address; floats it when not owner
// RL2: 8-bit two-way tri-state data bus between processor and memory or I/O
// RL3: I/O modules pull eight open-collector interrupt lines; never drive high
// RL4: low memory-read strobe marks fetch from full 16-bit address
// RL5: low memory-write strobe marks store of data bus at 16-bit address
// RL6: processor asserts I/O-read strobe; only low eight address lines select
// RL7: processor asserts I/O-write strobe; only low eight address lines select
// RL8: interrupt-acknowledge strobe fetches restart instruction from data bus
// RL9: exactly the strobe matching the current cycle type is asserted
// RL10: request strobes are low-active open-collector so DMA owners drive them
// RL11: strobes timed so modules use them directly as gates and clocks
// RL12: hold request answered by hold acknowledge once in hold state
// RL13: hold acknowledge is open-collector, low for the whole hold state
// RL14: data buffers released while data-bus-release input is low
// RL15: address buffers released while address-bus-release input is low
// RL16: hold and release signals only matter when DMA modules exist
// RL17: with a DMA arbiter fitted, it alone raises the hold request
// RL18: each DMA module requests on its own line of eight
// RL19: arbiter drives eight low grant lines; granted module runs one cycle
// RL20: low wait line stretches the current cycle while asserted
// RL21: memory and I/O modules decode only their own switch-set base
// RL22: arbiter freezes priority during hold, drops request after pending served
module mbb_master (
  input  wire logic                    clk_in,
  input  wire logic                    rstn_in,
  // processor side
  input  wire logic                    cyc_req_in,
  input  wire mbb_pkg::mbb_cyc_e       cyc_type_in,
  input  wire logic [`MBB_ADDR_W-1:0]  cyc_addr_in,
  input  wire logic [`MBB_DATA_W-1:0]  cyc_wdata_in,
  output logic                         cyc_busy_out,
  output logic                         cyc_done_out,
  output logic      [`MBB_DATA_W-1:0]  cyc_rdata_out,
  output logic                         cyc_waited_out,
  output logic                         hold_state_out,
  output logic      [`MBB_IRQ_W-1:0]   irq_pending_out,
  // backplane address and data
  output logic      [`MBB_ADDR_W-1:0]  addr_out,
  output logic                         addr_oe_out,
  input  wire logic [`MBB_DATA_W-1:0]  data_in,
  output logic      [`MBB_DATA_W-1:0]  data_out,
  output logic                         data_oe_out,
  // request strobes, bit map in mbb_regs.svh
  input  wire logic [`MBB_NSTRB-1:0]   req_strobes_n_in,
  output logic      [`MBB_NSTRB-1:0]   req_strobes_n_out,
  output logic      [`MBB_NSTRB-1:0]   req_strobes_oe_out,
  // dma handshake and control lines
  input  wire logic                    bus_hold_request_n_in,
  output logic                         bus_hold_grant_n_out,
  output logic                         bus_hold_grant_oe_out,
  input  wire logic                    addr_buffer_release_n_in,
  input  wire logic                    data_buffer_release_n_in,
  input  wire logic                    cycle_wait_n_in,
  input  wire logic [`MBB_IRQ_W-1:0]   irq_lines_n_in
);
  import mbb_pkg::*;

  typedef struct packed {
    mbb_state_e                 st;
    mbb_cyc_e                   kind;
    logic [`MBB_ADDR_W-1:0]     addr;
    logic [`MBB_DATA_W-1:0]     wdata;
    logic [`MBB_DATA_W-1:0]     rdata;
    logic                       busy;
    logic                       done;
    logic                       waited;
    logic                       own_addr;
    logic                       own_data;
    logic                       addr_oe;
    logic                       data_oe;
    logic [`MBB_NSTRB-1:0]      strb_oe;
    logic                       grant_oe;
    logic                       oc_lvl;
    logic [`MBB_IRQ_W-1:0]      irq_pend;
  } mbb_top_s;

  mbb_top_s r;
  mbb_top_s r_nxt;

  // synchronised pins
  logic [`MBB_SY_W-1:0]    sy;
  logic                    wait_on;
  logic                    hold_on;
  logic                    arel_on;
  logic                    drel_on;
  logic [`MBB_DATA_W-1:0]  bus_data;
  logic [`MBB_IRQ_W-1:0]   irq_n;
  logic [`MBB_NSTRB-1:0]   strb_n;
  logic                    tick;
  logic                    is_read;
  logic                    is_io;
  logic [`MBB_NSTRB-1:0]   strb_sel;

  mbb_tick_if tk ();

  mbb_sync #(
    .W       (`MBB_SY_W),
    .RST_VAL (`MBB_SY_IDLE)
  ) u_sync (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .pins_in  ({req_strobes_n_in, irq_lines_n_in, data_in,
                data_buffer_release_n_in, addr_buffer_release_n_in,
                bus_hold_request_n_in, cycle_wait_n_in}),
    .sync_out (sy)
  );

  mbb_phase_div u_div (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .tk      (tk)
  );

  assign wait_on  = ~sy[`MBB_SY_WAIT];
  assign hold_on  = ~sy[`MBB_SY_HOLD];
  assign arel_on  = ~sy[`MBB_SY_AREL];
  assign drel_on  = ~sy[`MBB_SY_DREL];
  assign bus_data = sy[`MBB_SY_DATA +: `MBB_DATA_W];
  assign irq_n    = sy[`MBB_SY_IRQ +: `MBB_IRQ_W];
  assign strb_n   = sy[`MBB_SY_STRB +: `MBB_NSTRB];
  assign tick     = tk.tick;

  // divider runs only while there is something to pace
  assign tk.run = r.busy | cyc_req_in | hold_on | (r.st == MBB_ST_HOLD);

  // cycle kind decode for the latched cycle
  always_comb begin
    is_read  = 1'b0;
    is_io    = 1'b0;
    strb_sel = '0;
    case (r.kind)
      MBB_CYC_MEM_READ: begin
        is_read                       = 1'b1;
        strb_sel[`MBB_STRB_MEM_READ]  = 1'b1; // see RL4
      end
      MBB_CYC_MEM_WRITE: begin
        strb_sel[`MBB_STRB_MEM_WRITE] = 1'b1; // see RL5
      end
      MBB_CYC_IO_READ: begin
        is_read                       = 1'b1;
        is_io                         = 1'b1;
        strb_sel[`MBB_STRB_IO_READ]   = 1'b1; // see RL6
      end
      MBB_CYC_IO_WRITE: begin
        is_io                         = 1'b1;
        strb_sel[`MBB_STRB_IO_WRITE]  = 1'b1; // see RL7
      end
      MBB_CYC_INT_ACK: begin
        is_read                       = 1'b1;
        strb_sel[`MBB_STRB_INT_ACK]   = 1'b1; // see RL8
      end
      default: begin
        strb_sel = '0;
      end
    endcase
  end

  always_comb begin
    r_nxt          = r;
    r_nxt.done     = 1'b0;
    r_nxt.oc_lvl   = `MBB_OC_LVL;
    r_nxt.irq_pend = ~irq_n; // see RL3
    case (r.st)
      MBB_ST_IDLE: begin
        // hold wins over a new cycle; a cycle in flight always finishes
        if (tick && hold_on) begin
          r_nxt.st       = MBB_ST_HOLD;
          r_nxt.grant_oe = 1'b1; // see RL12
        end else if (tick && cyc_req_in && (&strb_n)) begin // see RL10 RL19
          r_nxt.st       = MBB_ST_ADDR;
          r_nxt.kind     = cyc_type_in;
          r_nxt.wdata    = cyc_wdata_in;
          r_nxt.busy     = 1'b1;
          r_nxt.waited   = 1'b0;
          r_nxt.own_addr = 1'b1; // see RL1
          r_nxt.own_data = (cyc_type_in == MBB_CYC_MEM_WRITE) ||
                           (cyc_type_in == MBB_CYC_IO_WRITE); // see RL2
          if ((cyc_type_in == MBB_CYC_IO_READ) ||
              (cyc_type_in == MBB_CYC_IO_WRITE)) begin
            // upper lines held quiet; units decode the low byte only
            r_nxt.addr = {`MBB_IO_ADDR_HI,
                          cyc_addr_in[`MBB_IO_ADDR_W-1:0]}; // see RL6 RL7
          end else begin
            r_nxt.addr = cyc_addr_in; // see RL4 RL5
          end
        end
      end
      MBB_ST_ADDR: begin
        // address and write data settle a whole phase before the strobe
        if (tick) begin
          r_nxt.st      = MBB_ST_STRB;
          r_nxt.strb_oe = strb_sel; // see RL9 RL10 RL11
        end
      end
      MBB_ST_STRB: begin
        if (tick && wait_on) begin
          r_nxt.waited = 1'b1; // see RL20
        end else if (tick) begin
          r_nxt.st      = MBB_ST_TAIL;
          r_nxt.strb_oe = '0; // see RL11
        end
      end
      MBB_ST_TAIL: begin
        // data pins lag two flops, so take them in step with the synchronised
        // strobes: only copies made while the strobe was still low count
        if (is_read && !(&strb_n)) begin
          r_nxt.rdata = bus_data; // see RL4 RL6 RL8
        end
        // address and data stay one phase after the strobe edge
        if (tick) begin
          r_nxt.st       = MBB_ST_IDLE;
          r_nxt.own_addr = 1'b0; // see RL1
          r_nxt.own_data = 1'b0;
          r_nxt.busy     = 1'b0;
          r_nxt.done     = 1'b1;
        end
      end
      MBB_ST_HOLD: begin
        // grant stays low for the whole hold state
        if (tick && !hold_on) begin
          r_nxt.st       = MBB_ST_IDLE;
          r_nxt.grant_oe = 1'b0; // see RL13
        end
      end
      default: begin
        r_nxt.st       = MBB_ST_IDLE;
        r_nxt.strb_oe  = '0;
        r_nxt.own_addr = 1'b0;
        r_nxt.own_data = 1'b0;
        r_nxt.grant_oe = 1'b0;
        r_nxt.busy     = 1'b0;
      end
    endcase
    // release inputs only gate the buffers; sequencing is untouched
    r_nxt.addr_oe = r_nxt.own_addr & ~arel_on; // see RL15 RL16
    r_nxt.data_oe = r_nxt.own_data & ~drel_on; // see RL14 RL16
    // a read never drives data; is_read is stale in idle, so it is only used outside idle
    if (is_read && (r.st != MBB_ST_IDLE)) begin
      r_nxt.data_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r.st       <= MBB_ST_IDLE;
      r.kind     <= MBB_CYC_MEM_READ;
      r.addr     <= `MBB_ADDR_RST;
      r.wdata    <= `MBB_DATA_RST;
      r.rdata    <= `MBB_DATA_RST;
      r.busy     <= 1'b0;
      r.done     <= 1'b0;
      r.waited   <= 1'b0;
      r.own_addr <= 1'b0;
      r.own_data <= 1'b0;
      r.addr_oe  <= 1'b0;
      r.data_oe  <= 1'b0;
      r.strb_oe  <= `MBB_STRB_OE_RST;
      r.grant_oe <= 1'b0;
      r.oc_lvl   <= `MBB_OC_LVL;
      r.irq_pend <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign cyc_busy_out          = r.busy;
  assign cyc_done_out          = r.done;
  assign cyc_rdata_out         = r.rdata;
  assign cyc_waited_out        = r.waited;
  assign hold_state_out        = r.grant_oe;
  assign irq_pending_out       = r.irq_pend;
  assign addr_out              = r.addr;
  assign addr_oe_out           = r.addr_oe;
  assign data_out              = r.wdata;
  assign data_oe_out           = r.data_oe;
  assign req_strobes_n_out     = {`MBB_NSTRB{r.oc_lvl}};
  assign req_strobes_oe_out    = r.strb_oe;
  assign bus_hold_grant_n_out  = r.oc_lvl;
  assign bus_hold_grant_oe_out = r.grant_oe;

  // is_io kept for decode clarity of the address mux above
  logic unused_io;
  assign unused_io = is_io;

endmodule : mbb_master

`default_nettype wire

/* testbench/mbb_master_asserts.sv */
// concurrent checks on the backplane bus master top ports
// assumes a bind from the bench; strobe bit map as in mbb_regs.svh
`timescale 1ns/1ps
`default_nettype none
`include "mbb_regs.svh"

module mbb_master_chk (
  input wire logic                   clk_in,
  input wire logic                   rstn_in,
  input wire mbb_pkg::mbb_cyc_e      cyc_type_in,
  input wire logic                   cyc_busy_out,
  input wire logic                   cyc_done_out,
  input wire logic                   cyc_waited_out,
  input wire logic                   hold_state_out,
  input wire logic [`MBB_ADDR_W-1:0] addr_out,
  input wire logic                   addr_oe_out,
  input wire logic                   data_oe_out,
  input wire logic [`MBB_NSTRB-1:0]  req_strobes_n_out,
  input wire logic [`MBB_NSTRB-1:0]  req_strobes_oe_out,
  input wire logic                   bus_hold_request_n_in,
  input wire logic                   bus_hold_grant_n_out,
  input wire logic                   bus_hold_grant_oe_out,
  input wire logic                   addr_buffer_release_n_in,
  input wire logic                   data_buffer_release_n_in
);
  import mbb_pkg::*;

  mbb_cyc_e   typ_r;
  logic [7:0] busy_cnt_r;

  // latched only while idle, so it holds the accepted kind for the whole cycle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      typ_r      <= MBB_CYC_MEM_READ;
      busy_cnt_r <= 8'h00;
    end else begin
      if (!cyc_busy_out)
        typ_r <= cyc_type_in;
      busy_cnt_r <= cyc_busy_out ? busy_cnt_r + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  strobe_match_a: assert property ((|req_strobes_oe_out) |->
    req_strobes_oe_out == (5'h01 << typ_r)) else $error("strobe differs from cycle kind");
  strobe_oc_a: assert property (req_strobes_n_out == 5'h00)
    else $error("strobe driven high");
  grant_oc_a: assert property (bus_hold_grant_n_out == 1'b0 &&
    bus_hold_grant_oe_out == hold_state_out) else $error("grant not open collector");
  grant_cause_a: assert property ($rose(bus_hold_grant_oe_out) |->
    !$past(bus_hold_request_n_in, 2) && !cyc_busy_out) else $error("grant without request");
  grant_idle_a: assert property (bus_hold_grant_oe_out |->
    req_strobes_oe_out == 5'h00 && !addr_oe_out) else $error("bus used during hold");
  data_release_a: assert property (!data_buffer_release_n_in [*4] |->
    !data_oe_out) else $error("data driven while released");
  addr_release_a: assert property (!addr_buffer_release_n_in [*4] |->
    !addr_oe_out) else $error("address driven while released");
  addr_stable_a: assert property ((|req_strobes_oe_out) |-> $stable(addr_out))
    else $error("address moved under strobe");
  io_addr_a: assert property ((req_strobes_oe_out[2] || req_strobes_oe_out[3]) |->
    addr_out[15:8] == 8'h00) else $error("io cycle upper address not zero");
  write_drive_a: assert property (data_oe_out |->
    typ_r == MBB_CYC_MEM_WRITE || typ_r == MBB_CYC_IO_WRITE) else $error("data driven on read");
  cycle_len_a: assert property (cyc_done_out |->
    (cyc_waited_out ? busy_cnt_r > 8'h06 : busy_cnt_r == 8'h06)) else $error("cycle length");
  strobe_width_a: assert property ($rose(|req_strobes_oe_out) |=>
    (|req_strobes_oe_out)) else $error("strobe shorter than two clocks");
endmodule : mbb_master_chk

`default_nettype wire

/* testbench/mbb_far_model.sv */
// far side of the backplane: one memory module, one io unit, interrupt answer
// assumes the bench resolves the bus levels (pull-ups on strobes and wait)
`timescale 1ns/1ps
`default_nettype none
`include "mbb_regs.svh"

module mbb_far_model #(
  parameter logic [7:0] BASE_HI  = 8'h40,
  parameter logic [7:0] RST_CODE = 8'hEF
) (
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  input  wire logic [`MBB_NSTRB-1:0]  strobes_n_in,
  input  wire logic [`MBB_ADDR_W-1:0] addr_in,
  input  wire logic [`MBB_DATA_W-1:0] data_in,
  input  wire logic [3:0]             wait_cycles_in,
  output logic      [`MBB_DATA_W-1:0] data_out,
  output logic                        wait_n_out
);
  logic [7:0] mem [0:255];
  logic [7:0] io  [0:255];
  logic [7:0] last_r;
  logic [3:0] wcnt_r;
  logic       idle_r;
  wire logic  mem_hit = addr_in[15:8] == BASE_HI;

  // strobes used straight as write clocks, no resync
  always_ff @(posedge strobes_n_in[`MBB_STRB_MEM_WRITE]) begin
    if (mem_hit)
      mem[addr_in[7:0]] <= data_in;
  end
  always_ff @(posedge strobes_n_in[`MBB_STRB_IO_WRITE]) begin
    io[addr_in[7:0]] <= data_in;
  end

  // released bus shows a toggling value, never a stale one
  always_comb begin
    if (!strobes_n_in[`MBB_STRB_MEM_READ] && mem_hit)
      data_out = mem[addr_in[7:0]];
    else if (!strobes_n_in[`MBB_STRB_IO_READ])
      data_out = io[addr_in[7:0]];
    else if (!strobes_n_in[`MBB_STRB_INT_ACK])
      data_out = RST_CODE;
    else
      data_out = ~last_r;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      last_r <= 8'h00;
      wcnt_r <= 4'h0;
      idle_r <= 1'b1;
    end else begin
      last_r <= data_out;
      // wait starts on address decode: a reply to the strobe itself would
      // reach the master after its two-flop pin path had already sampled
      idle_r <= !mem_hit;
      if (idle_r && mem_hit)
        wcnt_r <= wait_cycles_in;
      else if (wcnt_r != 4'h0)
        wcnt_r <= wcnt_r - 4'h1;
    end
  end
  assign wait_n_out = (wcnt_r == 4'h0);
endmodule : mbb_far_model

`default_nettype wire

/* testbench/test_modular_backplane_bus.sv */
// self-checking bench for the backplane bus master and a far-side model
// assumes mbb_pkg, mbb_regs.svh and the design sources compiled first
`timescale 1ns/1ps
`default_nettype none
`include "mbb_regs.svh"

module test_modular_backplane_bus;
  import mbb_pkg::*;
  localparam logic [7:0] RST_CODE = 8'hEF;
  logic        clk = 1'b0, rstn = 1'b0, req = 1'b0;
  mbb_cyc_e    typ = MBB_CYC_MEM_READ;
  logic [15:0] adr = 16'h0000;
  logic [7:0]  wdat = 8'h00, irq_n = 8'hFF;
  logic        hold_n = 1'b1, arel_n = 1'b1, drel_n = 1'b1;
  logic [4:0]  ext_n = 5'h1F;
  logic [3:0]  wait_cyc = 4'h0;
  logic        busy, done, waited, hstate, aoe, doe, gnt_n, gnt_oe, wait_n;
  logic        seen_aoe, seen_doe;
  logic [7:0]  rdata, pend, dout, mdrv;
  logic [15:0] aout;
  logic [4:0]  strb_oe;
  wire logic [15:0] abus = aoe ? aout : ~aout;
  wire logic [7:0]  dbus = doe ? dout : mdrv;
  wire logic [4:0]  sbus = ~strb_oe & ext_n;
  int          failures = 0, cmp_count = 0;

  always #50 clk = ~clk;

  mbb_master i_mbb_master (.clk_in(clk), .rstn_in(rstn), .cyc_req_in(req),
    .cyc_type_in(typ), .cyc_addr_in(adr), .cyc_wdata_in(wdat), .cyc_busy_out(busy),
    .cyc_done_out(done), .cyc_rdata_out(rdata), .cyc_waited_out(waited),
    .hold_state_out(hstate), .irq_pending_out(pend), .addr_out(aout), .addr_oe_out(aoe),
    .data_in(dbus), .data_out(dout), .data_oe_out(doe), .req_strobes_n_in(sbus),
    .req_strobes_n_out(), .req_strobes_oe_out(strb_oe), .bus_hold_request_n_in(hold_n),
    .bus_hold_grant_n_out(gnt_n), .bus_hold_grant_oe_out(gnt_oe),
    .addr_buffer_release_n_in(arel_n), .data_buffer_release_n_in(drel_n),
    .cycle_wait_n_in(wait_n), .irq_lines_n_in(irq_n));

  mbb_far_model #(.RST_CODE(RST_CODE)) i_mbb_far_model (.clk_in(clk), .rstn_in(rstn),
    .strobes_n_in(sbus), .addr_in(abus), .data_in(dbus), .wait_cycles_in(wait_cyc),
    .data_out(mdrv), .wait_n_out(wait_n));

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // one machine cycle; n counts busy clocks, enables seen are recorded
  task automatic cyc(input mbb_cyc_e t, input logic [15:0] a, input logic [7:0] w,
                     output logic [7:0] rd, output int n);
    int k;
    n = 0;
    k = 0;
    seen_aoe = 1'b0;
    seen_doe = 1'b0;
    typ = t;
    adr = a;
    wdat = w;
    req = 1'b1;
    while (busy !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    req = 1'b0;
    while (done !== 1'b1 && k < 80) begin
      seen_aoe |= aoe;
      seen_doe |= doe;
      tick(1);
      k++;
      n++;
    end
    chk("cycle end", 16'(done), 16'h0001);
    rd = rdata;
  endtask : cyc

  task automatic t_mem;
    logic [7:0] rd;
    int n;
    cyc(MBB_CYC_MEM_WRITE, 16'h40A5, 8'h3C, rd, n);
    chk("write enables", 16'({seen_aoe, seen_doe}), 16'h0003);
    chk("write length", 16'(n), 16'h0006);
    cyc(MBB_CYC_MEM_READ, 16'h40A5, 8'h00, rd, n);
    chk("read data", 16'(rd), 16'h003C);
    chk("read data enable", 16'(seen_doe), 16'h0000);
  endtask : t_mem

  task automatic t_io;
    logic [7:0] rd;
    int n;
    cyc(MBB_CYC_IO_WRITE, 16'hAB34, 8'h77, rd, n);
    cyc(MBB_CYC_IO_READ, 16'h0034, 8'h00, rd, n);
    chk("io read data", 16'(rd), 16'h0077);
    cyc(MBB_CYC_INT_ACK, 16'h0000, 8'h00, rd, n);
    chk("restart code", 16'(rd), 16'(RST_CODE));
  endtask : t_io

  task automatic t_wait;
    logic [7:0] rd;
    int n;
    wait_cyc = 4'h6;
    cyc(MBB_CYC_MEM_READ, 16'h40A5, 8'h00, rd, n);
    wait_cyc = 4'h0;
    chk("waited data", 16'(rd), 16'h003C);
    chk("waited flag", 16'({waited, n > 6}), 16'h0003);
  endtask : t_wait

  // hold request, then a dma owner on the strobe lines, must both refuse cycles
  task automatic t_block;
    logic [7:0] rd;
    int n;
    for (int i = 0; i < 2; i++) begin
      if (i == 0)
        hold_n = 1'b0;
      else
        ext_n = 5'h1E;
      tick(4);
      typ = MBB_CYC_MEM_READ;
      req = 1'b1;
      tick(12);
      chk("refused", 16'(busy), 16'h0000);
      if (i == 0)
        chk("grant", 16'({gnt_oe, hstate, gnt_n}), 16'h0006);
      hold_n = 1'b1;
      ext_n = 5'h1F;
      cyc(MBB_CYC_MEM_READ, 16'h40A5, 8'h00, rd, n);
      chk("after blocker", 16'({gnt_oe, rd}), 16'h003C);
    end
  endtask : t_block

  task automatic t_release;
    logic [7:0] rd;
    int n;
    arel_n = 1'b0;
    drel_n = 1'b0;
    tick(4);
    cyc(MBB_CYC_MEM_WRITE, 16'h4011, 8'h55, rd, n);
    chk("addr released", 16'(seen_aoe), 16'h0000);
    chk("data released", 16'(seen_doe), 16'h0000);
    arel_n = 1'b1;
    drel_n = 1'b1;
    tick(4);
  endtask : t_release

  task automatic t_irq;
    irq_n = 8'hA5;
    tick(4);
    chk("irq pending", 16'(pend), 16'h005A);
    irq_n = 8'hFF;
  endtask : t_irq

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    tick(16);
    rstn = 1'b1;
    tick(2);
    chk("idle enables", 16'({aoe, doe, gnt_oe, strb_oe, busy}), 16'h0000);
    t_mem;
    t_io;
    t_wait;
    t_block;
    t_release;
    t_irq;
    wrap_up;
  end

  // the sequence needs well under a thousand clocks
  initial begin
    #(100 * 3000);
    failures++;
    wrap_up;
  end
endmodule : test_modular_backplane_bus

bind mbb_master mbb_master_chk i_mbb_master_chk (.clk_in, .rstn_in, .cyc_type_in,
  .cyc_busy_out, .cyc_done_out, .cyc_waited_out, .hold_state_out, .addr_out, .addr_oe_out,
  .data_oe_out, .req_strobes_n_out, .req_strobes_oe_out, .bus_hold_request_n_in,
  .bus_hold_grant_n_out, .bus_hold_grant_oe_out, .addr_buffer_release_n_in,
  .data_buffer_release_n_in);

`default_nettype wire
